// *** src/csbu_pkg.sv ***
// shared constants and types for the compare, skip and branch unit
package csbu_pkg;

	// status flag bit positions
	localparam int FLAG_C       = 0;            // carry
	localparam int FLAG_Z       = 1;            // zero
	localparam int FLAG_N       = 2;            // negative
	localparam int FLAG_V       = 3;            // two's complement overflow
	localparam int FLAG_H       = 5;            // half carry

	// widths
	localparam int DATA_W       = 8;            // register and immediate width
	localparam int STATUS_FLAGS_REGISTER_W       = 8;            // status flags register width
	localparam int BIT_SEL_W    = 3;            // bit select width
	localparam int OFS_W        = 7;            // signed branch offset width
	localparam int HALF_BIT     = 3;            // bit feeding the half carry
	localparam int PC_W_DEF     = 16;           // default program counter width

	// program counter steps
	localparam int SKIP_ONE_WORD = 2;           // skip over a one-word instruction
	localparam int SKIP_TWO_WORD = 3;           // skip over a two-word instruction
	localparam int BRANCH_STEP   = 1;           // added on top of the offset

	// reset value of the flags copy driven out
	localparam logic [7:0] STATUS_FLAGS_REGISTER_RST = 8'h00;

	// operations handed over by the decoder
	typedef enum logic [3:0] {
		CSBU_OP_NONE                  = 4'h0,
		CSBU_OP_REGISTER_COMPARE      = 4'h1,
		CSBU_OP_COMPARE_WITH_BORROW   = 4'h2,
		CSBU_OP_IMMEDIATE_COMPARE     = 4'h3,
		CSBU_OP_COMPARE_SKIP_EQUAL    = 4'h4,
		CSBU_OP_SKIP_REG_BIT_CLEAR    = 4'h5,
		CSBU_OP_SKIP_REG_BIT_SET      = 4'h6,
		CSBU_OP_SKIP_IO_BIT_CLEAR     = 4'h7,
		CSBU_OP_SKIP_IO_BIT_SET       = 4'h8,
		CSBU_OP_BRANCH_FLAG_SET       = 4'h9,
		CSBU_OP_BRANCH_FLAG_CLEAR     = 4'ha,
		CSBU_OP_BRANCH_ON_EQUAL       = 4'hb,
		CSBU_OP_BRANCH_ON_UNEQUAL     = 4'hc,
		CSBU_OP_BRANCH_ON_CARRY       = 4'hd,
		CSBU_OP_BRANCH_SAME_OR_HIGHER = 4'he
	} csbu_op_e;

	// sequencer states, gray coded along idle, hold_a, hold_last
	typedef enum logic [1:0] {
		CSBU_ST_IDLE      = 2'h0,
		CSBU_ST_HOLD_A    = 2'h1,
		CSBU_ST_HOLD_LAST = 2'h3
	} csbu_state_e;

endpackage : csbu_pkg

// *** src/csbu_sub_flags.sv ***
// subtractor that derives compare flags without producing a result
module csbu_sub_flags
	import csbu_pkg::*;
#(
	parameter int W = DATA_W                    // operand width
)
(
	input  wire logic [W-1:0] a_val,            // minuend
	input  wire logic [W-1:0] b_val,            // subtrahend
	input  wire logic         borrow_in,        // borrow taken from carry
	input  wire logic         zero_chain,       // keep prior zero into result
	input  wire logic         zero_prev,        // prior zero flag
	output logic              c_flag,           // borrow out
	output logic              z_flag,           // zero
	output logic              n_flag,           // negative
	output logic              v_flag,           // overflow
	output logic              h_flag            // half borrow
);

	logic [W-1:0] diff;                         // discarded difference

	// plain difference, wraps on purpose
	always_comb
	begin
		diff = a_val - b_val - {{(W-1){1'b0}}, borrow_in};
	end

	// flag equations of a subtract
	always_comb
	begin
		c_flag = (~a_val[W-1] & b_val[W-1]) | (b_val[W-1] & diff[W-1]) | (diff[W-1] & ~a_val[W-1]);
		h_flag = (~a_val[HALF_BIT] & b_val[HALF_BIT]) | (b_val[HALF_BIT] & diff[HALF_BIT])
			| (diff[HALF_BIT] & ~a_val[HALF_BIT]);
		v_flag = (a_val[W-1] & ~b_val[W-1] & ~diff[W-1]) | (~a_val[W-1] & b_val[W-1] & diff[W-1]);
		n_flag = diff[W-1];
		// chained zero lets multi-byte compares stay zero only if all bytes were
		z_flag = (diff == '0) & (~zero_chain | zero_prev);
	end

endmodule : csbu_sub_flags

// *** src/csbu_top.sv ***
// compare, skip and conditional branch execution unit
// Behaviour
// - register compare sets flags, writes no result
// - immediate compare sets flags, register untouched
// - equal registers skip via pc plus 2/3
// - compare skip takes 1, 2 or 3 cycles
// - register bit clear skips next instruction
// - register bit set skips next instruction
// - io bit clear skips next instruction
// - io bit set skips next instruction
// - branch when selected flag is one
// - branch when selected flag is zero
// - branch on equal when zero set
// - branch on unequal when zero clear
// - branch on carry when carry set
// - branch same or higher when carry clear
module csbu_top
	import csbu_pkg::*;
#(
	parameter int PC_W = PC_W_DEF               // program counter width in words
)
(
	input  wire logic                 clk,           // core clock
	input  wire logic                 resetn,        // synchronous reset, low active
	input  wire logic                 op_valid,      // decoder presents an operation
	input  wire csbu_op_e             op_code,       // operation to execute
	input  wire logic [DATA_W-1:0]    rd_val,        // destination register value
	input  wire logic [DATA_W-1:0]    rr_val,        // source register value
	input  wire logic [DATA_W-1:0]    imm_val,       // embedded constant
	input  wire logic [DATA_W-1:0]    io_val,        // io register value
	input  wire logic [BIT_SEL_W-1:0] bit_sel,       // bit tested by skips
	input  wire logic [BIT_SEL_W-1:0] flag_sel,      // flag tested by branches
	input  wire logic [OFS_W-1:0]     branch_ofs,    // signed relative offset
	input  wire logic [PC_W-1:0]      pc_cur,        // address of this instruction
	input  wire logic                 next_two_word, // following instruction is two words
	input  wire logic [STATUS_FLAGS_REGISTER_W-1:0]    status_flags_register_in,       // current status flags register
	output logic                      busy,          // unit is holding extra cycles
	output logic                      done,          // operation completed, pulse
	output logic [STATUS_FLAGS_REGISTER_W-1:0]         status_flags_register_out,      // new status flags register
	output logic                      status_flags_register_we,       // write strobe for flags, pulse
	output logic [PC_W-1:0]           pc_out,        // program counter target
	output logic                      pc_load        // load strobe for pc, pulse
);

	// operation class decoders, used by logic and checks
	function automatic logic is_cmp(input csbu_op_e op);
		is_cmp = (op == CSBU_OP_REGISTER_COMPARE) | (op == CSBU_OP_COMPARE_WITH_BORROW)
			| (op == CSBU_OP_IMMEDIATE_COMPARE);
	endfunction : is_cmp

	function automatic logic is_skip(input csbu_op_e op);
		is_skip = (op >= CSBU_OP_COMPARE_SKIP_EQUAL) & (op <= CSBU_OP_SKIP_IO_BIT_SET);
	endfunction : is_skip

	function automatic logic is_branch(input csbu_op_e op);
		is_branch = (op >= CSBU_OP_BRANCH_FLAG_SET) & (op <= CSBU_OP_BRANCH_SAME_OR_HIGHER);
	endfunction : is_branch

	csbu_state_e     state_q;               // sequencer state
	csbu_state_e     state_d;               // sequencer next state
	logic            accept;                // operation taken this cycle
	logic            skip_now;              // skip condition met
	logic            take_branch;           // branch condition met
	logic [DATA_W-1:0] cmp_b;               // compare subtrahend
	logic            cmp_borrow;            // carry used as borrow
	logic            sub_c;                 // subtract carry
	logic            sub_z;                 // subtract zero
	logic            sub_n;                 // subtract negative
	logic            sub_v;                 // subtract overflow
	logic            sub_h;                 // subtract half carry
	logic [PC_W-1:0] branch_target;         // pc plus offset plus one
	logic [PC_W-1:0] skip_target;           // pc plus two or three
	logic [PC_W-1:0] pend_pc_q;             // skip target held during extra cycles
	logic [STATUS_FLAGS_REGISTER_W-1:0] status_flags_register_q;              // registered flags out
	logic            status_flags_register_we_q;             // registered flag strobe
	logic [PC_W-1:0] pc_q;                  // registered pc target
	logic            pc_load_q;             // registered pc strobe
	logic            done_q;                // registered completion

	// a new operation is only taken while idle
	always_comb
	begin
		accept = op_valid & (state_q == CSBU_ST_IDLE);
	end

	// compare operand selection
	always_comb
	begin
		cmp_b      = (op_code == CSBU_OP_IMMEDIATE_COMPARE) ? imm_val : rr_val;
		cmp_borrow = (op_code == CSBU_OP_COMPARE_WITH_BORROW) & status_flags_register_in[FLAG_C];
	end

	// only the borrow compare chains zero, so a long compare tests all bytes
	csbu_sub_flags #(
		.W          (DATA_W)
	) u_sub (
		.a_val      (rd_val),
		.b_val      (cmp_b),
		.borrow_in  (cmp_borrow),
		.zero_chain (op_code == CSBU_OP_COMPARE_WITH_BORROW),
		.zero_prev  (status_flags_register_in[FLAG_Z]),
		.c_flag     (sub_c),
		.z_flag     (sub_z),
		.n_flag     (sub_n),
		.v_flag     (sub_v),
		.h_flag     (sub_h)
	);

	// skip condition per operation
	always_comb
	begin
		case (op_code)
			CSBU_OP_COMPARE_SKIP_EQUAL: skip_now = (rd_val == rr_val);
			CSBU_OP_SKIP_REG_BIT_CLEAR: skip_now = ~rr_val[bit_sel];
			CSBU_OP_SKIP_REG_BIT_SET:   skip_now = rr_val[bit_sel];
			CSBU_OP_SKIP_IO_BIT_CLEAR:  skip_now = ~io_val[bit_sel];
			CSBU_OP_SKIP_IO_BIT_SET:    skip_now = io_val[bit_sel];
			default:                    skip_now = 1'b0;                    // not a skip
		endcase
	end

	// branch condition per operation
	always_comb
	begin
		case (op_code)
			CSBU_OP_BRANCH_FLAG_SET:       take_branch = status_flags_register_in[flag_sel];
			CSBU_OP_BRANCH_FLAG_CLEAR:     take_branch = ~status_flags_register_in[flag_sel];
			CSBU_OP_BRANCH_ON_EQUAL:       take_branch = status_flags_register_in[FLAG_Z];
			CSBU_OP_BRANCH_ON_UNEQUAL:     take_branch = ~status_flags_register_in[FLAG_Z];
			CSBU_OP_BRANCH_ON_CARRY:       take_branch = status_flags_register_in[FLAG_C];
			CSBU_OP_BRANCH_SAME_OR_HIGHER: take_branch = ~status_flags_register_in[FLAG_C];
			default:                       take_branch = 1'b0;                // not a branch
		endcase
	end

	// targets; the offset is sign extended so backward branches wrap correctly
	always_comb
	begin
		branch_target = pc_cur + {{(PC_W-OFS_W){branch_ofs[OFS_W-1]}}, branch_ofs}
			+ PC_W'(BRANCH_STEP);
		skip_target   = pc_cur + (next_two_word ? PC_W'(SKIP_TWO_WORD)
			: PC_W'(SKIP_ONE_WORD));
	end

	// sequencer next state: extra cycles only for a skip that happens
	always_comb
	begin
		case (state_q)
			CSBU_ST_IDLE:
			begin
				if (accept & skip_now)
					state_d = next_two_word ? CSBU_ST_HOLD_A : CSBU_ST_HOLD_LAST;
				else
					state_d = CSBU_ST_IDLE;
			end
			CSBU_ST_HOLD_A:    state_d = CSBU_ST_HOLD_LAST;             // third cycle follows
			CSBU_ST_HOLD_LAST: state_d = CSBU_ST_IDLE;                  // finishing
			default:           state_d = CSBU_ST_IDLE;                  // unused code
		endcase
	end

	// sequencer state register
	always_ff @(posedge clk)
	begin
		if (!resetn)
			state_q <= CSBU_ST_IDLE;
		else
			state_q <= state_d;
	end

	// hold the skip target while the skipped words are discarded
	always_ff @(posedge clk)
	begin
		if (!resetn)
			pend_pc_q <= '0;
		else if (accept & skip_now)
			pend_pc_q <= skip_target;
	end

	// flag write only for compares; skips and branches leave flags alone
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			status_flags_register_q    <= STATUS_FLAGS_REGISTER_RST;
			status_flags_register_we_q <= 1'b0;
		end
		else
		begin
			status_flags_register_we_q <= accept & is_cmp(op_code);
			if (accept & is_cmp(op_code))
			begin
				status_flags_register_q         <= status_flags_register_in;                              // other flags kept
				status_flags_register_q[FLAG_C] <= sub_c;
				status_flags_register_q[FLAG_Z] <= sub_z;
				status_flags_register_q[FLAG_N] <= sub_n;
				status_flags_register_q[FLAG_V] <= sub_v;
				status_flags_register_q[FLAG_H] <= sub_h;
			end
		end
	end

	// pc load: branches at once, skips when the last extra cycle ends
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			pc_q      <= '0;
			pc_load_q <= 1'b0;
		end
		else if (accept & is_branch(op_code) & take_branch)
		begin
			pc_q      <= branch_target;
			pc_load_q <= 1'b1;
		end
		else if (state_q == CSBU_ST_HOLD_LAST)
		begin
			pc_q      <= pend_pc_q;
			pc_load_q <= 1'b1;
		end
		else
			pc_load_q <= 1'b0;                                          // sequential flow
	end

	// completion pulse
	always_ff @(posedge clk)
	begin
		if (!resetn)
			done_q <= 1'b0;
		else
			done_q <= (accept & ~skip_now) | (state_q == CSBU_ST_HOLD_LAST);
	end

	// outputs; busy is decoded from the registered state, so it rises the cycle after a skip is accepted
	assign busy     = (state_q != CSBU_ST_IDLE);
	assign done     = done_q;
	assign status_flags_register_out = status_flags_register_q;
	assign status_flags_register_we  = status_flags_register_we_q;
	assign pc_out   = pc_q;
	assign pc_load  = pc_load_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	// steps of a skip, and the start of a compare
	sequence s_skip_one;
		accept && skip_now && !next_two_word;
	endsequence
	sequence s_skip_two;
		accept && skip_now && next_two_word;
	endsequence
	sequence s_cmp_start;
		accept && is_cmp(op_code);
	endsequence

	chk_cmp_flags_c: assert property (s_cmp_start |=> status_flags_register_we && !pc_load && status_flags_register_out[FLAG_C] == $past(sub_c))
		else $error("compare carry flag wrong");
	chk_borrow_zero: assert property (accept && op_code == CSBU_OP_COMPARE_WITH_BORROW && !status_flags_register_in[FLAG_Z]
		|=> !status_flags_register_out[FLAG_Z])
		else $error("borrow compare zero not chained");
	chk_imm_compare: assert property (accept && op_code == CSBU_OP_IMMEDIATE_COMPARE
		|=> status_flags_register_we && done && status_flags_register_out[FLAG_Z] == ($past(rd_val) == $past(imm_val)))
		else $error("immediate compare zero wrong");
	chk_skip_one_word: assert property (s_skip_one |=> busy && !done ##1 done && pc_load
		&& pc_out == PC_W'($past(pc_cur, 2) + PC_W'(SKIP_ONE_WORD)))
		else $error("one word skip target or timing wrong");
	chk_skip_no_skip: assert property (accept && is_skip(op_code) && !skip_now |=> done && !pc_load && !busy)
		else $error("unskipped skip op not single cycle");
	chk_skip_two_word: assert property (s_skip_two |=> !done [*2] ##1 done && pc_load
		&& pc_out == PC_W'($past(pc_cur, 3) + PC_W'(SKIP_TWO_WORD)))
		else $error("two word skip target or timing wrong");
	// bounded by the skip's own completion, so a legal op taken right after it is not blamed
	chk_skip_no_flags: assert property (accept && is_skip(op_code) |=> !status_flags_register_we throughout (##[0:2] done))
		else $error("skip touched flags");
	chk_io_bit_skip: assert property (accept && (op_code == CSBU_OP_SKIP_IO_BIT_SET
		|| op_code == CSBU_OP_SKIP_IO_BIT_CLEAR) |=> busy == ($past(io_val[bit_sel])
		== ($past(op_code) == CSBU_OP_SKIP_IO_BIT_SET)))
		else $error("io bit skip decision wrong");
	chk_branch_taken: assert property (accept && is_branch(op_code) && take_branch |=> pc_load && done
		&& !status_flags_register_we && pc_out == $past(branch_target))
		else $error("taken branch wrong");
	chk_branch_equal: assert property (accept && op_code == CSBU_OP_BRANCH_ON_EQUAL |=> pc_load == $past(status_flags_register_in[FLAG_Z]))
		else $error("branch on equal decision wrong");
	chk_branch_unequal: assert property (accept && op_code == CSBU_OP_BRANCH_ON_UNEQUAL |=> pc_load != $past(status_flags_register_in[FLAG_Z]))
		else $error("branch on unequal decision wrong");
	chk_branch_carry: assert property (accept && (op_code == CSBU_OP_BRANCH_ON_CARRY
		|| op_code == CSBU_OP_BRANCH_SAME_OR_HIGHER) |=> pc_load == ($past(status_flags_register_in[FLAG_C])
		== ($past(op_code) == CSBU_OP_BRANCH_ON_CARRY)))
		else $error("carry branch decision wrong");

endmodule : csbu_top

// *** verification/tb_compare_skip_branch_unit.sv ***
// self-checking bench for the compare, skip and branch unit
module tb_compare_skip_branch_unit
	import csbu_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// one table row: stimulus beside the expected outcome
	typedef struct {
		csbu_op_e    op;                        // operation
		logic [7:0]  a;                         // destination register
		logic [7:0]  b;                         // source register
		logic [7:0]  k;                         // embedded constant
		logic [7:0]  io;                        // io register
		logic [2:0]  sel;                       // bit or flag select
		logic [6:0]  ofs;                       // branch offset
		logic        two;                       // next instruction is two words
		logic [7:0]  sr;                        // incoming flags
		logic        take;                      // skip or branch expected
	} csbu_tb_row_s;

	logic                 clk;                  // core clock
	logic                 resetn;               // synchronous reset, low active
	logic                 op_valid;             // operation strobe
	csbu_op_e             op_code;              // operation
	logic [DATA_W-1:0]    rd_val;               // destination value
	logic [DATA_W-1:0]    rr_val;               // source value
	logic [DATA_W-1:0]    imm_val;              // constant
	logic [DATA_W-1:0]    io_val;               // io value
	logic [BIT_SEL_W-1:0] bit_sel;              // skip bit
	logic [BIT_SEL_W-1:0] flag_sel;             // branch flag
	logic [OFS_W-1:0]     branch_ofs;           // relative offset
	logic [15:0]          pc_cur;               // instruction address
	logic                 next_two_word;        // skipped length
	logic [STATUS_FLAGS_REGISTER_W-1:0]    status_flags_register_in;              // flags in
	logic                 busy;                 // extra skip cycles
	logic                 done;                 // completion pulse
	logic [STATUS_FLAGS_REGISTER_W-1:0]    status_flags_register_out;             // flags out
	logic                 status_flags_register_we;              // flags strobe
	logic [15:0]          pc_out;               // pc target
	logic                 pc_load;              // pc strobe
	int                   err_count;            // mismatches
	int                   checks_done;          // comparisons

	// ordinary cases: compares, every skip both ways, every branch both ways
	csbu_tb_row_s rows [31] = '{
		'{CSBU_OP_REGISTER_COMPARE, 8'h10, 8'h10, 8'h00, 8'h00, 3'h0, 7'h00, 1'b0, 8'h00, 1'b0},
		'{CSBU_OP_REGISTER_COMPARE, 8'h00, 8'h01, 8'h00, 8'h00, 3'h0, 7'h00, 1'b0, 8'h00, 1'b0},
		'{CSBU_OP_REGISTER_COMPARE, 8'h80, 8'h01, 8'h00, 8'h00, 3'h0, 7'h00, 1'b0, 8'hff, 1'b0},
		'{CSBU_OP_COMPARE_WITH_BORROW, 8'h05, 8'h05, 8'h00, 8'h00, 3'h0, 7'h00, 1'b0, 8'h01, 1'b0},
		'{CSBU_OP_COMPARE_WITH_BORROW, 8'h05, 8'h05, 8'h00, 8'h00, 3'h0, 7'h00, 1'b0, 8'h02, 1'b0},
		'{CSBU_OP_COMPARE_WITH_BORROW, 8'h05, 8'h04, 8'h00, 8'h00, 3'h0, 7'h00, 1'b0, 8'hd3, 1'b0},
		'{CSBU_OP_IMMEDIATE_COMPARE, 8'h3f, 8'h3f, 8'h40, 8'h00, 3'h0, 7'h00, 1'b0, 8'h00, 1'b0},
		'{CSBU_OP_COMPARE_SKIP_EQUAL, 8'h5a, 8'h5a, 8'h00, 8'h00, 3'h0, 7'h00, 1'b0, 8'h00, 1'b1},
		'{CSBU_OP_COMPARE_SKIP_EQUAL, 8'h5a, 8'h5a, 8'h00, 8'h00, 3'h0, 7'h00, 1'b1, 8'h00, 1'b1},
		'{CSBU_OP_COMPARE_SKIP_EQUAL, 8'h5a, 8'h5b, 8'h00, 8'h00, 3'h0, 7'h00, 1'b0, 8'h00, 1'b0},
		'{CSBU_OP_SKIP_REG_BIT_CLEAR, 8'h00, 8'hf7, 8'h00, 8'hff, 3'h3, 7'h00, 1'b1, 8'h00, 1'b1},
		'{CSBU_OP_SKIP_REG_BIT_CLEAR, 8'h00, 8'h08, 8'h00, 8'h00, 3'h3, 7'h00, 1'b0, 8'h00, 1'b0},
		'{CSBU_OP_SKIP_REG_BIT_SET, 8'h00, 8'h80, 8'h00, 8'h00, 3'h7, 7'h00, 1'b0, 8'h00, 1'b1},
		'{CSBU_OP_SKIP_REG_BIT_SET, 8'h00, 8'h7f, 8'h00, 8'hff, 3'h7, 7'h00, 1'b0, 8'h00, 1'b0},
		'{CSBU_OP_SKIP_IO_BIT_CLEAR, 8'h00, 8'hff, 8'h00, 8'hfe, 3'h0, 7'h00, 1'b0, 8'h00, 1'b1},
		'{CSBU_OP_SKIP_IO_BIT_CLEAR, 8'h00, 8'h00, 8'h00, 8'h01, 3'h0, 7'h00, 1'b0, 8'h00, 1'b0},
		'{CSBU_OP_SKIP_IO_BIT_SET, 8'h00, 8'h00, 8'h00, 8'h04, 3'h2, 7'h00, 1'b1, 8'h00, 1'b1},
		'{CSBU_OP_SKIP_IO_BIT_SET, 8'h00, 8'hff, 8'h00, 8'hfb, 3'h2, 7'h00, 1'b0, 8'h00, 1'b0},
		'{CSBU_OP_BRANCH_FLAG_SET, 8'h00, 8'h00, 8'h00, 8'h00, 3'h6, 7'h7f, 1'b0, 8'h40, 1'b1},
		'{CSBU_OP_BRANCH_FLAG_SET, 8'h00, 8'h00, 8'h00, 8'h00, 3'h6, 7'h7f, 1'b0, 8'hbf, 1'b0},
		'{CSBU_OP_BRANCH_FLAG_CLEAR, 8'h00, 8'h00, 8'h00, 8'h00, 3'h4, 7'h3f, 1'b0, 8'h00, 1'b1},
		'{CSBU_OP_BRANCH_FLAG_CLEAR, 8'h00, 8'h00, 8'h00, 8'h00, 3'h4, 7'h3f, 1'b0, 8'h10, 1'b0},
		'{CSBU_OP_BRANCH_ON_EQUAL, 8'h00, 8'h00, 8'h00, 8'h00, 3'h0, 7'h05, 1'b0, 8'h02, 1'b1},
		'{CSBU_OP_BRANCH_ON_EQUAL, 8'h00, 8'h00, 8'h00, 8'h00, 3'h0, 7'h05, 1'b0, 8'hfd, 1'b0},
		'{CSBU_OP_BRANCH_ON_UNEQUAL, 8'h00, 8'h00, 8'h00, 8'h00, 3'h0, 7'h0a, 1'b0, 8'hfd, 1'b1},
		'{CSBU_OP_BRANCH_ON_UNEQUAL, 8'h00, 8'h00, 8'h00, 8'h00, 3'h0, 7'h0a, 1'b0, 8'h02, 1'b0},
		'{CSBU_OP_BRANCH_ON_CARRY, 8'h00, 8'h00, 8'h00, 8'h00, 3'h0, 7'h40, 1'b0, 8'h01, 1'b1},
		'{CSBU_OP_BRANCH_ON_CARRY, 8'h00, 8'h00, 8'h00, 8'h00, 3'h0, 7'h40, 1'b0, 8'hfe, 1'b0},
		'{CSBU_OP_BRANCH_SAME_OR_HIGHER, 8'h00, 8'h00, 8'h00, 8'h00, 3'h0, 7'h01, 1'b0, 8'hfe, 1'b1},
		'{CSBU_OP_BRANCH_SAME_OR_HIGHER, 8'h00, 8'h00, 8'h00, 8'h00, 3'h0, 7'h01, 1'b0, 8'h01, 1'b0},
		'{CSBU_OP_NONE, 8'h00, 8'h00, 8'h00, 8'h00, 3'h0, 7'h00, 1'b0, 8'h00, 1'b0}
	};

	csbu_top i_dut (
		.clk           (clk),
		.resetn        (resetn),
		.op_valid      (op_valid),
		.op_code       (op_code),
		.rd_val        (rd_val),
		.rr_val        (rr_val),
		.imm_val       (imm_val),
		.io_val        (io_val),
		.bit_sel       (bit_sel),
		.flag_sel      (flag_sel),
		.branch_ofs    (branch_ofs),
		.pc_cur        (pc_cur),
		.next_two_word (next_two_word),
		.status_flags_register_in       (status_flags_register_in),
		.busy          (busy),
		.done          (done),
		.status_flags_register_out      (status_flags_register_out),
		.status_flags_register_we       (status_flags_register_we),
		.pc_out        (pc_out),
		.pc_load       (pc_load)
	);

	// free-running core clock, 5 ns period
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// verdict and end of run, reached from the main flow and from any stuck wait
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test

	// one comparison, reported at once on mismatch
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e)
		begin
			err_count++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// reference flags: difference of minuend and subtrahend, borrow and zero chained for the borrow form
	function automatic logic [7:0] exp_flags(input csbu_tb_row_s r);
		logic [7:0] b;
		logic [7:0] d;
		logic       c;
		b = (r.op == CSBU_OP_IMMEDIATE_COMPARE) ? r.k : r.b;
		c = (r.op == CSBU_OP_COMPARE_WITH_BORROW) & r.sr[FLAG_C];
		d = r.a - b - {7'h00, c};
		exp_flags = r.sr;
		exp_flags[FLAG_C] = (~r.a[7] & b[7]) | (b[7] & d[7]) | (d[7] & ~r.a[7]);
		exp_flags[FLAG_H] = (~r.a[3] & b[3]) | (b[3] & d[3]) | (d[3] & ~r.a[3]);
		exp_flags[FLAG_N] = d[7];
		exp_flags[FLAG_V] = (r.a[7] & ~b[7] & ~d[7]) | (~r.a[7] & b[7] & d[7]);
		exp_flags[FLAG_Z] = (d == 8'h00) & ((r.op != CSBU_OP_COMPARE_WITH_BORROW) | r.sr[FLAG_Z]);
	endfunction : exp_flags

	// present one operation, called just after a falling edge
	task automatic drive(input csbu_tb_row_s r, input logic [15:0] pc);
		op_valid      = 1'b1;
		op_code       = r.op;
		rd_val        = r.a;
		rr_val        = r.b;
		imm_val       = r.k;
		io_val        = r.io;
		bit_sel       = r.sel;
		flag_sel      = r.sel;
		branch_ofs    = r.ofs;
		pc_cur        = pc;
		next_two_word = r.two;
		status_flags_register_in       = r.sr;
	endtask : drive

	// expected target: skip by instruction length, branch by signed offset plus one
	function automatic logic [15:0] exp_pc(input csbu_tb_row_s r, input logic [15:0] pc);
		if (r.op inside {[CSBU_OP_COMPARE_SKIP_EQUAL:CSBU_OP_SKIP_IO_BIT_SET]})
			exp_pc = pc + (r.two ? 16'h0003 : 16'h0002);
		else
			exp_pc = pc + {{9{r.ofs[6]}}, r.ofs} + 16'h0001;
	endfunction : exp_pc

	// one whole operation with a bounded wait for completion
	task automatic run_row(input csbu_tb_row_s r, input logic [15:0] pc);
		int   n;
		logic skp;
		logic cmp;
		skp = r.take && (r.op inside {[CSBU_OP_COMPARE_SKIP_EQUAL:CSBU_OP_SKIP_IO_BIT_SET]});
		cmp = r.op inside {[CSBU_OP_REGISTER_COMPARE:CSBU_OP_IMMEDIATE_COMPARE]};
		drive(r, pc);
		@(negedge clk);
		op_valid = 1'b0;
		chk("busy", skp, busy);
		n = 1;
		while (done !== 1'b1 && n < 8)
		begin
			@(negedge clk);
			n++;
		end
		if (done !== 1'b1)
		begin
			err_count++;
			$display("FAIL done expected 1 seen %b", done);
			stop_test();
		end
		chk("cycles", skp ? (r.two ? 16'h0003 : 16'h0002) : 16'h0001, n[15:0]);
		chk("status_flags_register_we", cmp, status_flags_register_we);
		if (cmp)
			chk("status_flags_register_out", exp_flags(r), status_flags_register_out);
		chk("pc_load", r.take, pc_load);
		if (r.take)
			chk("pc_out", exp_pc(r, pc), pc_out);
	endtask : run_row

	// all outputs at their reset values
	task automatic chk_rst();
		chk("rst busy", 16'h0000, busy);
		chk("rst strobes", 16'h0000, {done, status_flags_register_we, pc_load});
		chk("rst status_flags_register_out", 16'h0000, status_flags_register_out);
		chk("rst pc_out", 16'h0000, pc_out);
	endtask : chk_rst

	// main sequence
	initial
	begin
		err_count   = 0;
		checks_done = 0;
		resetn      = 1'b0;
		drive(rows[0], 16'h0000);
		repeat (8) @(negedge clk);
		chk_rst();
		// request withdrawn before release, so the first edge after reset is idle
		op_valid = 1'b0;
		resetn = 1'b1;
		@(negedge clk);
		foreach (rows[i])
		begin
			run_row(rows[i], 16'h1000 + i[15:0]);
			@(negedge clk);
		end
		// back to back compares, one per cycle
		drive(rows[0], 16'h0000);
		@(negedge clk);
		chk("b2b first", exp_flags(rows[0]), status_flags_register_out);
		drive(rows[1], 16'h0000);
		@(negedge clk);
		op_valid = 1'b0;
		chk("b2b second", exp_flags(rows[1]), status_flags_register_out);
		chk("b2b we", 16'h0001, status_flags_register_we);
		@(negedge clk);
		// a request held during a skip is ignored until busy falls
		drive(rows[7], 16'h0200);
		@(negedge clk);
		chk("held busy", 16'h0001, busy);
		drive(rows[22], 16'h0300);
		@(negedge clk);
		chk("held skip pc", 16'h0202, pc_out);
		chk("held skip done", 16'h0003, {done, pc_load});
		@(negedge clk);
		chk("held branch pc", 16'h0306, pc_out);
		chk("held branch done", 16'h0003, {done, pc_load});
		// second reset in mid-run
		drive(rows[8], 16'h0400);
		@(negedge clk);
		op_valid = 1'b0;
		resetn   = 1'b0;
		@(negedge clk);
		chk_rst();
		resetn = 1'b1;
		@(negedge clk);
		chk_rst();
		run_row(rows[8], 16'h0500);
		stop_test();
	end

endmodule : tb_compare_skip_branch_unit
